// ---- bench/adc_src.sv ----
// file: converter model feeding the eight channel results
`timescale 1ns/1ps
module adc_src (
	input wire logic [15:0] base,
	output aia_pkg::adc_chan_s [7:0] adc_in
);
	// ramp on base, channel 5 negative, 6 over range, 7 under range
	always_comb begin
		for (int c = 0; c < 8; c++) begin
			adc_in[c].value = (c == 5) ? -base : base + 16'(c);
			adc_in[c].over = (c == 6);
			adc_in[c].under = (c == 7);
		end
	end
endmodule // adc_src

// ---- bench/aia_asserts.sv ----
// file: port checks of the acquisition block
`timescale 1ns/1ps
module aia_asserts (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic irq
);
	logic scope_m; // scope mode written
	logic [7:0] rd_a; // last read address
	logic aw_t, ar_t; // takes
	assign aw_t = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	assign ar_t = s_axi_arvalid && s_axi_arready;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// track mode and read address from bus traffic
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scope_m <= 1'b0;
			rd_a <= 8'h00;
		end else begin
			if (aw_t && s_axi_awaddr == aia_pkg::ADDR_CTRL)
				scope_m <= s_axi_wdata[1:0] == 2'h1;
			if (ar_t)
				rd_a <= s_axi_araddr;
		end
	end
	AST_B_LAT: assert property (aw_t |-> ##2 s_axi_bvalid)
		else $error("write response late");
	AST_R_LAT: assert property (ar_t |-> ##3 s_axi_rvalid)
		else $error("read data late");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	AST_AR_BUSY: assert property (ar_t |=> !s_axi_arready [*3])
		else $error("read taken while busy");
	AST_BAD_RD: assert property (ar_t && (s_axi_araddr[1:0] != 2'h0 || s_axi_araddr > 8'h50) |-> ##3 s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("unmapped read answered");
	AST_CHV_WORD: assert property (s_axi_rvalid && rd_a >= 8'h20 && rd_a <= 8'h3C |-> s_axi_rdata[31:16] == 16'h0)
		else $error("channel word too wide");
	AST_IRQ_SCOPE: assert property (scope_m && $past(scope_m, 4) |-> !irq)
		else $error("irq in scope mode");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (irq);
	cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // aia_asserts
bind analog_input_acquisition_modes aia_asserts u_chk (.aclk, .aresetn, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);

// ---- bench/tb.sv ----
// file: self-checking bench of the acquisition block
`timescale 1ns/1ps
module tb;
	logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, dig = 0;
	logic [7:0] awa = 0, ara = 0, slot = 8'h65;
	logic [31:0] wd = 0, rd_d, d;
	logic [15:0] base = 16'h0100; // converter base value
	logic awr, wrd, bv, arr, rv, irq;
	logic [1:0] br, rr, rs;
	aia_pkg::adc_chan_s [7:0] adc;
	int n_errors = 0, samples_checked = 0;
	// short counts: 100 us as 20 cycles, ring of 6
	analog_input_acquisition_modes #(.BASE_CYC(20), .FAST_CYC(5), .FIFO_DEPTH(6)) dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_d),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .adc_in(adc),
		.slot_number(slot), .digital_io_module(dig), .irq(irq));
	adc_src u_adc (.base(base), .adc_in(adc));
	initial forever #4 aclk = ~aclk;
	task end_of_test;
		if (n_errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// compare seen against expected
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			$display("Error %s expected %h seen %h", nm, e, s);
			n_errors++;
		end
	endtask
	// a wait that ran out
	task tmo(input bit f);
		if (f) begin
			n_errors++;
			end_of_test;
		end
	endtask
	// register write, both channels offered together
	task wr(input logic [7:0] a, input logic [31:0] v);
		int i;
		@(posedge aclk);
		awa <= a;
		wd <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		for (i = 0; i < 200; i++) begin
			@(posedge aclk);
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
			if (bv === 1'b1) break;
		end
		rs = br;
		bry <= 1'b0;
		tmo(i == 200);
	endtask
	// register read into d and rs
	task rd(input logic [7:0] a);
		int i;
		@(posedge aclk);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		for (i = 0; i < 200; i++) begin
			@(posedge aclk);
			if (arr) arv <= 1'b0;
			if (rv === 1'b1) break;
		end
		d = rd_d;
		rs = rr;
		rry <= 1'b0;
		tmo(i == 200);
	endtask
	task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(nm, d, e);
	endtask
	// expected channel word from the converter model
	function logic [31:0] ev(input int c);
		case (c)
			5: return {16'h0, -base};
			6: return 32'h7FFF;
			7: return 32'h8000;
			default: return {16'h0, base + 16'(c)};
		endcase
	endfunction
	initial begin
		int s;
		int t;
		void'($urandom(32'h9fe8761d));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		// start address of random slots, both kinds
		for (t = 0; t < 4; t++) begin
			s = 101 + $urandom % 10;
			slot <= 8'(s);
			dig <= t[0];
			repeat (6) @(posedge aclk);
			s = t[0] ? 4 * (s - 101) + 128 : 256 * (s - 101) + 2048;
			rc("start", aia_pkg::ADDR_START, 32'(s));
		end
		// standard scan of all channels
		base <= 16'h0100 + 16'($urandom % 3840);
		repeat (60) @(posedge aclk);
		for (t = 0; t < 8; t++)
			rc("chv", aia_pkg::ADDR_CHV0 + 8'(4 * t), ev(t));
		// factor above range flags an error; an illegal mode forces 7FFF at the next tick
		wr(aia_pkg::ADDR_CYCLE, 32'h259);
		rd(aia_pkg::ADDR_STATUS);
		chk("range", d & 32'h10, 32'h10);
		wr(aia_pkg::ADDR_CYCLE, 32'h1);
		wr(aia_pkg::ADDR_CTRL, 32'h3);
		repeat (60) @(posedge aclk);
		rc("perr", aia_pkg::ADDR_CHV0 + 8'h08, 32'h7FFF);
		// end of cycle event and interrupt
		wr(aia_pkg::ADDR_CTRL, 32'h4);
		wr(aia_pkg::ADDR_CYCLE, 32'h1);
		wr(aia_pkg::ADDR_IRQ_STAT, 32'h7);
		repeat (60) @(posedge aclk);
		rc("eoc_short", aia_pkg::ADDR_IRQ_STAT, 32'h0);
		wr(aia_pkg::ADDR_CYCLE, 32'h2);
		repeat (100) @(posedge aclk);
		rc("eoc", aia_pkg::ADDR_IRQ_STAT, 32'h1);
		wr(aia_pkg::ADDR_IRQ_MASK, 32'h7);
		repeat (3) @(posedge aclk);
		chk("irq", 32'(irq), 32'h1);
		// scope, eight channels, command start, run to full
		wr(aia_pkg::ADDR_CTRL, 32'h31);
		repeat (3) @(posedge aclk);
		chk("irq_scope", 32'(irq), 32'h0);
		wr(aia_pkg::ADDR_IRQ_STAT, 32'h7);
		wr(aia_pkg::ADDR_CYCLE, 32'h0);
		wr(aia_pkg::ADDR_CMD, 32'h1);
		for (t = 0; t < 420; t++) begin
			repeat (200) @(posedge aclk);
			rd(aia_pkg::ADDR_STATUS);
			if (d[2]) break;
		end
		tmo(t == 420);
		rc("done", aia_pkg::ADDR_IRQ_STAT, 32'h2);
		chk("irq_done", 32'(irq), 32'h0);
		wr(aia_pkg::ADDR_SCOPE_IDX, 32'h0);
		rc("mem_first", aia_pkg::ADDR_SCOPE_DATA, 32'h10000 | ev(0));
		wr(aia_pkg::ADDR_SCOPE_IDX, 32'hFFFF);
		rc("mem_last", aia_pkg::ADDR_SCOPE_DATA, 32'h10000 | ev(7));
		// rising then falling trigger on channel 0, then stop by new cycle
		for (t = 1; t < 3; t++) begin
			base <= (t == 1) ? 16'h1000 : 16'h6000;
			wr(aia_pkg::ADDR_TRIG, 32'h4000);
			wr(aia_pkg::ADDR_CTRL, 32'(1 + 64 * t));
			wr(aia_pkg::ADDR_CMD, 32'h1);
			repeat (30) @(posedge aclk);
			rd(aia_pkg::ADDR_STATUS);
			chk("armed", d & 32'h3, 32'h2);
			base <= (t == 1) ? 16'h6000 : 16'h1000;
			repeat (30) @(posedge aclk);
			rd(aia_pkg::ADDR_STATUS);
			chk("rec", d & 32'h3, 32'h1);
			wr(aia_pkg::ADDR_CYCLE, 32'h0);
			rd(aia_pkg::ADDR_STATUS);
			chk("stop", d & 32'h1, 32'h0);
		end
		// ring overrun, sticky error, packet read
		wr(aia_pkg::ADDR_IRQ_STAT, 32'h7);
		wr(aia_pkg::ADDR_CTRL, 32'h2);
		wr(aia_pkg::ADDR_CMD, 32'h1);
		repeat (80) @(posedge aclk);
		wr(aia_pkg::ADDR_CMD, 32'h2);
		rd(aia_pkg::ADDR_STATUS);
		chk("ovf", d & 32'hFF08, 32'hFF00);
		rd(aia_pkg::ADDR_STATUS);
		chk("ovf_read", d & 32'hFF00, 32'h0);
		rc("ovf_irq", aia_pkg::ADDR_IRQ_STAT, 32'h4);
		chk("irq_ovf", 32'(irq), 32'h1);
		wr(aia_pkg::ADDR_FIFO_SEL, 32'h3);
		rc("level", aia_pkg::ADDR_FIFO_LEVEL, 32'h6);
		rc("pop", aia_pkg::ADDR_FIFO_DATA, 32'h10000 | ev(3));
		rc("level", aia_pkg::ADDR_FIFO_LEVEL, 32'h5);
		// unmapped place
		rc("bad_rd", 8'h60, 32'h0);
		chk("rresp", 32'(rs), 32'(aia_pkg::RESP_SLVERR));
		wr(8'h60, 32'h1);
		chk("bresp", 32'(rs), 32'(aia_pkg::RESP_SLVERR));
		end_of_test;
	end
endmodule // tb

// ---- rtl/aia_pkg.sv ----
// package: constants, register map and carriers of the analog input acquisition block
package aia_pkg;
	localparam int CLK_MHZ = 125; // aclk rate
	localparam int T_BASE_US = 100; // unit of the cycle factor
	localparam int T_FAST_US = 25; // cycle when the factor is zero
	localparam int BASE_CYC = T_BASE_US * CLK_MHZ; // cycles per factor unit
	localparam int FAST_CYC = T_FAST_US * CLK_MHZ; // cycles of the fast cycle
	localparam int NCH = 8; // input channels
	localparam int MEM_AW = 16; // recording memory, 65536 values
	localparam int FIFO_DEPTH = 8190; // values per channel ring
	localparam int FIFO_AW = 13; // ring index width
	localparam logic [9:0] FACTOR_MAX = 10'h258; // 600
	localparam logic [9:0] FACTOR_IRQ_MIN = 10'h002; // 200 us
	localparam logic [9:0] FACTOR_RST = 10'h001;
	localparam logic [15:0] VAL_OVER = 16'h7FFF;
	localparam logic [15:0] VAL_UNDER = 16'h8000;
	localparam logic [15:0] SLOT_FIRST = 16'h0065; // 101
	localparam logic [15:0] DIO_STEP = 16'h0004;
	localparam logic [15:0] DIO_BASE = 16'h0080;
	localparam logic [15:0] AIO_STEP = 16'h0100;
	localparam logic [15:0] AIO_BASE = 16'h0800;
	// register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CYCLE = 8'h04;
	localparam logic [7:0] ADDR_CMD = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
	localparam logic [7:0] ADDR_TRIG = 8'h18;
	localparam logic [7:0] ADDR_START = 8'h1C;
	localparam logic [7:0] ADDR_CHV0 = 8'h20; // 8h20..8h3C channel values
	localparam logic [7:0] ADDR_FIFO_SEL = 8'h40;
	localparam logic [7:0] ADDR_FIFO_DATA = 8'h44;
	localparam logic [7:0] ADDR_FIFO_LEVEL = 8'h48;
	localparam logic [7:0] ADDR_SCOPE_IDX = 8'h4C;
	localparam logic [7:0] ADDR_SCOPE_DATA = 8'h50;
	// interrupt status bits
	localparam int IRQ_EOC = 0;
	localparam int IRQ_DONE = 1;
	localparam int IRQ_OVF = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {MODE_STD = 2'h0, MODE_SCOPE = 2'h1, MODE_FIFO = 2'h2} mode_e;
	typedef enum logic [1:0] {TRIG_CMD = 2'h0, TRIG_RISE = 2'h1, TRIG_FALL = 2'h2} trig_e;
	typedef enum logic [3:0] {SC_IDLE = 4'h1, SC_ARMED = 4'h2, SC_REC = 4'h4,
		SC_DONE = 4'h8} scope_e;
	typedef enum logic [3:0] {RD_IDLE = 4'h1, RD_MEM = 4'h2, RD_LAT = 4'h4,
		RD_RESP = 4'h8} rd_e;
	// one converter result with its range flags
	typedef struct packed {
		logic over;
		logic under;
		logic [15:0] value;
	} adc_chan_s;
endpackage

// ---- rtl/analog_input_acquisition_modes.sv ----
// file: acquisition modes, sample recording and AXI4-Lite registers of the analog inputs
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module analog_input_acquisition_modes #(
	parameter int BASE_CYC = aia_pkg::BASE_CYC, // cycles per 100 us
	parameter int FAST_CYC = aia_pkg::FAST_CYC, // cycles per 25 us
	parameter int FIFO_DEPTH = aia_pkg::FIFO_DEPTH // values per channel ring
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire aia_pkg::adc_chan_s [7:0] adc_in,
	input wire logic [7:0] slot_number,
	input wire logic digital_io_module,
	output logic irq
);
	localparam int FW = aia_pkg::FIFO_AW;
	generate
		if (FIFO_DEPTH < 2 || FIFO_DEPTH > (1 << FW)) begin : g_bad
			$error("fifo depth must lie in 2..8192");
		end
	endgenerate
	localparam logic [FW-1:0] F_LAST = FW'(FIFO_DEPTH - 1);
	localparam logic [FW:0] F_FULL = (FW + 1)'(FIFO_DEPTH);
	// whole block state
	typedef struct packed {
		aia_pkg::adc_chan_s [7:0] sy1; // first sync stage
		aia_pkg::adc_chan_s [7:0] sy2; // second sync stage
		logic [7:0] slot1;
		logic [7:0] slot2;
		logic dig1;
		logic dig2;
		logic [15:0] start_addr; // automatic start address
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic aw_ok; // write address held
		logic w_ok; // write data held
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		aia_pkg::rd_e rd; // read path stage
		logic rd_mem; // answer comes from memory
		logic [31:0] rd_val;
		logic [1:0] mode; // raw mode field
		logic eoc_en;
		logic [1:0] chs; // scope channel count code
		logic [1:0] trig;
		logic [9:0] factor;
		logic [15:0] level;
		logic [2:0] trig_ch;
		logic [2:0] irq_stat;
		logic [2:0] irq_mask;
		logic irq;
		logic [7:0][15:0] ch_val; // latest converted set
		aia_pkg::scope_e sc;
		logic prev_above;
		logic [15:0] widx; // scope write index
		logic [15:0] ridx; // scope read index
		logic fifo_run;
		logic [7:0][FW-1:0] wptr;
		logic [7:0][FW-1:0] rptr;
		logic [7:0][FW:0] cnt;
		logic [7:0] ovf_err;
		logic [2:0] fifo_sel;
		logic seq_on; // storing the set channel by channel
		logic [2:0] seq_ch;
		logic mem_we;
		logic [15:0] mem_waddr;
		logic [15:0] mem_wdata;
		logic [15:0] mem_raddr;
		logic restart;
	} st_s;
	st_s s_r, s_nxt;
	logic tick; // scan cycle boundary
	logic [15:0] mem_rdata;
	logic param_err; // configuration out of range
	logic [31:0] m; // byte lane mask
	logic [31:0] v; // merged write value
	logic [2:0] ev; // interrupt events
	logic [7:0] ovf_ev;
	logic stat_rd; // status read clears overrun errors
	logic [15:0] tv; // trigger channel value
	logic above;
	logic [2:0] c;
	// range flags and parameter error replace the value
	function automatic logic [15:0] conv(input aia_pkg::adc_chan_s a, input logic perr);
		if (perr || a.over) begin
			conv = aia_pkg::VAL_OVER;
		end else if (a.under) begin
			conv = aia_pkg::VAL_UNDER;
		end else begin
			conv = a.value;
		end
	endfunction
	cycle_timer #(.BASE_CYC(BASE_CYC), .FAST_CYC(FAST_CYC)) u_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.restart(s_r.restart),
		.factor(s_r.factor),
		.tick(tick)
	);
	sample_mem #(.AW(aia_pkg::MEM_AW), .DW(16)) u_mem (
		.aclk(aclk),
		.we(s_r.mem_we),
		.waddr(s_r.mem_waddr),
		.wdata(s_r.mem_wdata),
		.raddr(s_r.mem_raddr),
		.rdata(mem_rdata)
	);
	// next state of the whole block
	always_comb begin
		s_nxt = s_r;
		ev = 3'h0;
		ovf_ev = 8'h00;
		stat_rd = 1'b0;
		m = 32'h0;
		v = 32'h0;
		c = s_r.seq_ch;
		s_nxt.mem_we = 1'b0;
		s_nxt.restart = 1'b0;
		param_err = (s_r.mode == 2'h3) || (s_r.factor > aia_pkg::FACTOR_MAX);
		// pins pass two flops
		s_nxt.sy1 = adc_in;
		s_nxt.sy2 = s_r.sy1;
		s_nxt.slot1 = slot_number;
		s_nxt.slot2 = s_r.slot1;
		s_nxt.dig1 = digital_io_module;
		s_nxt.dig2 = s_r.dig1;
		// slot based start address
		if (s_r.dig2) begin
			s_nxt.start_addr = aia_pkg::DIO_STEP * ({8'h00, s_r.slot2} - aia_pkg::SLOT_FIRST)
				+ aia_pkg::DIO_BASE;
		end else begin
			s_nxt.start_addr = aia_pkg::AIO_STEP * ({8'h00, s_r.slot2} - aia_pkg::SLOT_FIRST)
				+ aia_pkg::AIO_BASE;
		end
		tv = conv(s_r.sy2[s_r.trig_ch], param_err);
		above = $signed(tv) > $signed(s_r.level);
		// scan cycle end: new set of values
		if (tick) begin
			for (int i = 0; i < aia_pkg::NCH; i++) begin
				s_nxt.ch_val[i] = conv(s_r.sy2[i], param_err);
			end
			s_nxt.prev_above = above;
			if (s_r.mode == aia_pkg::MODE_STD && s_r.eoc_en
				&& s_r.factor >= aia_pkg::FACTOR_IRQ_MIN) begin
				ev[aia_pkg::IRQ_EOC] = 1'b1;
			end
			// armed scope watches the chosen edge
			if (s_r.sc == aia_pkg::SC_ARMED && ((s_r.trig == aia_pkg::TRIG_RISE
				&& !s_r.prev_above && above) || (s_r.trig == aia_pkg::TRIG_FALL
				&& s_r.prev_above && !above))) begin
				s_nxt.sc = aia_pkg::SC_REC;
			end
			if (s_nxt.sc == aia_pkg::SC_REC || s_r.fifo_run) begin
				s_nxt.seq_on = 1'b1;
				s_nxt.seq_ch = 3'h0;
			end
		end
		// store the set one channel per cycle
		if (s_r.seq_on) begin
			s_nxt.seq_ch = c + 3'h1;
			s_nxt.seq_on = (c != 3'h7);
			s_nxt.mem_wdata = s_r.ch_val[c];
			if (s_r.mode == aia_pkg::MODE_SCOPE && s_r.sc == aia_pkg::SC_REC) begin
				if (4'(c) < (4'h1 << s_r.chs)) begin
					s_nxt.mem_we = 1'b1;
					s_nxt.mem_waddr = s_r.widx;
					s_nxt.widx = s_r.widx + 16'h0001;
					if (s_r.widx == 16'hFFFF) begin
						s_nxt.sc = aia_pkg::SC_DONE;
						s_nxt.seq_on = 1'b0;
						ev[aia_pkg::IRQ_DONE] = 1'b1;
					end
				end
			end else if (s_r.mode == aia_pkg::MODE_FIFO && s_r.fifo_run) begin
				s_nxt.mem_we = 1'b1;
				s_nxt.mem_waddr = {c, s_r.wptr[c]};
				s_nxt.wptr[c] = (s_r.wptr[c] == F_LAST) ? '0 : s_r.wptr[c] + FW'(1);
				if (s_r.cnt[c] == F_FULL) begin
					s_nxt.rptr[c] = (s_r.rptr[c] == F_LAST) ? '0 : s_r.rptr[c] + FW'(1);
					ovf_ev[c] = 1'b1;
				end else begin
					s_nxt.cnt[c] = s_r.cnt[c] + (FW + 1)'(1);
				end
			end
		end
		// write address and data taken in either order
		if (s_axi_awvalid && s_r.awready) begin
			s_nxt.awready = 1'b0;
			s_nxt.aw_ok = 1'b1;
			s_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_r.wready) begin
			s_nxt.wready = 1'b0;
			s_nxt.w_ok = 1'b1;
			s_nxt.wdata = s_axi_wdata;
			s_nxt.wstrb = s_axi_wstrb;
		end
		// both held: perform the write
		if (s_r.aw_ok && s_r.w_ok && !s_r.bvalid) begin
			for (int b = 0; b < 4; b++) begin
				m[b * 8 +: 8] = {8{s_r.wstrb[b]}};
			end
			v = s_r.wdata & m;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = aia_pkg::RESP_OKAY;
			unique case (s_r.awaddr)
				aia_pkg::ADDR_CTRL, aia_pkg::ADDR_CYCLE: begin
					if (s_r.awaddr == aia_pkg::ADDR_CTRL) begin
						v = v | ({24'h0, s_r.trig, s_r.chs, 1'b0, s_r.eoc_en, s_r.mode} & ~m);
						s_nxt.mode = v[1:0];
						s_nxt.eoc_en = v[2];
						s_nxt.chs = v[5:4];
						s_nxt.trig = v[7:6];
					end else begin
						v = v | ({22'h0, s_r.factor} & ~m);
						s_nxt.factor = v[9:0];
					end
					// new parameters end any recording
					s_nxt.sc = aia_pkg::SC_IDLE;
					s_nxt.fifo_run = 1'b0;
					s_nxt.seq_on = 1'b0;
					s_nxt.mem_we = 1'b0;
					s_nxt.restart = 1'b1;
				end
				aia_pkg::ADDR_CMD: begin
					if (v[1]) begin
						s_nxt.sc = aia_pkg::SC_IDLE;
						s_nxt.fifo_run = 1'b0;
					end else if (v[0] && s_r.mode == aia_pkg::MODE_SCOPE) begin
						s_nxt.widx = 16'h0000;
						s_nxt.sc = (s_r.trig == aia_pkg::TRIG_CMD) ? aia_pkg::SC_REC
							: aia_pkg::SC_ARMED;
					end else if (v[0] && s_r.mode == aia_pkg::MODE_FIFO) begin
						s_nxt.fifo_run = 1'b1;
						s_nxt.wptr = '0;
						s_nxt.rptr = '0;
						s_nxt.cnt = '0;
					end
				end
				aia_pkg::ADDR_IRQ_STAT: begin
					s_nxt.irq_stat = s_r.irq_stat & ~v[2:0];
				end
				aia_pkg::ADDR_IRQ_MASK: begin
					s_nxt.irq_mask = (s_r.irq_mask & ~m[2:0]) | v[2:0];
				end
				aia_pkg::ADDR_TRIG: begin
					v = v | ({13'h0, s_r.trig_ch, s_r.level} & ~m);
					s_nxt.level = v[15:0];
					s_nxt.trig_ch = v[18:16];
				end
				aia_pkg::ADDR_FIFO_SEL: begin
					s_nxt.fifo_sel = m[0] ? v[2:0] : s_r.fifo_sel;
				end
				aia_pkg::ADDR_SCOPE_IDX: begin
					s_nxt.ridx = (v[15:0] | (s_r.ridx & ~m[15:0]));
				end
				default: begin
					s_nxt.bresp = aia_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
			s_nxt.aw_ok = 1'b0;
			s_nxt.w_ok = 1'b0;
			s_nxt.awready = 1'b1;
			s_nxt.wready = 1'b1;
		end
		// read path
		unique case (s_r.rd)
			aia_pkg::RD_IDLE: begin
				if (s_axi_arvalid) begin
					s_nxt.arready = 1'b0;
					s_nxt.rd = aia_pkg::RD_MEM;
					s_nxt.rd_mem = 1'b0;
					s_nxt.rd_val = 32'h0;
					s_nxt.rresp = aia_pkg::RESP_OKAY;
					if (s_axi_araddr[7:5] == 3'h1 && s_axi_araddr[1:0] == 2'h0) begin
						s_nxt.rd_val = {16'h0, s_r.ch_val[s_axi_araddr[4:2]]};
					end else begin
						unique case (s_axi_araddr)
							aia_pkg::ADDR_CTRL: s_nxt.rd_val = {24'h0, s_r.trig, s_r.chs,
								1'b0, s_r.eoc_en, s_r.mode};
							aia_pkg::ADDR_CYCLE: s_nxt.rd_val = {22'h0, s_r.factor};
							aia_pkg::ADDR_CMD: s_nxt.rd_val = 32'h0;
							aia_pkg::ADDR_STATUS: begin
								s_nxt.rd_val = {16'h0, s_r.ovf_err, 3'h0, param_err,
									s_r.fifo_run, s_r.sc == aia_pkg::SC_DONE,
									s_r.sc == aia_pkg::SC_ARMED, s_r.sc == aia_pkg::SC_REC};
								stat_rd = 1'b1;
							end
							aia_pkg::ADDR_IRQ_STAT: s_nxt.rd_val = {29'h0, s_r.irq_stat};
							aia_pkg::ADDR_IRQ_MASK: s_nxt.rd_val = {29'h0, s_r.irq_mask};
							aia_pkg::ADDR_TRIG: s_nxt.rd_val = {13'h0, s_r.trig_ch, s_r.level};
							aia_pkg::ADDR_START: s_nxt.rd_val = {16'h0, s_r.start_addr};
							aia_pkg::ADDR_FIFO_SEL: s_nxt.rd_val = {29'h0, s_r.fifo_sel};
							aia_pkg::ADDR_FIFO_LEVEL: s_nxt.rd_val = {18'h0,
								s_nxt.cnt[s_r.fifo_sel]};
							aia_pkg::ADDR_SCOPE_IDX: s_nxt.rd_val = {16'h0, s_r.ridx};
							aia_pkg::ADDR_FIFO_DATA: begin
								// packet read pops one value
								s_nxt.mem_raddr = {s_r.fifo_sel, s_nxt.rptr[s_r.fifo_sel]};
								if (s_nxt.cnt[s_r.fifo_sel] != '0) begin
									s_nxt.rd_mem = 1'b1;
									s_nxt.cnt[s_r.fifo_sel] = s_nxt.cnt[s_r.fifo_sel]
										- (FW + 1)'(1);
									s_nxt.rptr[s_r.fifo_sel] = (s_nxt.rptr[s_r.fifo_sel]
										== F_LAST) ? '0 : s_nxt.rptr[s_r.fifo_sel] + FW'(1);
								end
							end
							aia_pkg::ADDR_SCOPE_DATA: begin
								s_nxt.mem_raddr = s_r.ridx;
								s_nxt.ridx = s_r.ridx + 16'h0001;
								s_nxt.rd_mem = 1'b1;
							end
							default: s_nxt.rresp = aia_pkg::RESP_SLVERR;
						endcase
					end
				end
			end
			aia_pkg::RD_MEM: s_nxt.rd = aia_pkg::RD_LAT;
			aia_pkg::RD_LAT: begin
				s_nxt.rd = aia_pkg::RD_RESP;
				s_nxt.rvalid = 1'b1;
				s_nxt.rdata = s_r.rd_mem ? {15'h0, 1'b1, mem_rdata} : s_r.rd_val;
			end
			aia_pkg::RD_RESP: begin
				if (s_axi_rready) begin
					s_nxt.rvalid = 1'b0;
					s_nxt.arready = 1'b1;
					s_nxt.rd = aia_pkg::RD_IDLE;
				end
			end
			default: s_nxt.rd = aia_pkg::RD_IDLE;
		endcase
		// sticky flags: a new event wins over its clear
		if (ovf_ev != 8'h00) begin
			ev[aia_pkg::IRQ_OVF] = 1'b1;
		end
		s_nxt.ovf_err = (s_r.ovf_err & ~{8{stat_rd}}) | ovf_ev;
		s_nxt.irq_stat = s_nxt.irq_stat | ev;
		s_nxt.irq = ((s_nxt.irq_stat & s_nxt.irq_mask) != 3'h0)
			&& (s_nxt.mode != aia_pkg::MODE_SCOPE);
	end
	// state register with synchronous reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
			s_r.awready <= 1'b1;
			s_r.wready <= 1'b1;
			s_r.arready <= 1'b1;
			s_r.rd <= aia_pkg::RD_IDLE;
			s_r.sc <= aia_pkg::SC_IDLE;
			s_r.factor <= aia_pkg::FACTOR_RST;
		end else begin
			s_r <= s_nxt;
		end
	end
	assign s_axi_awready = s_r.awready;
	assign s_axi_wready = s_r.wready;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_arready = s_r.arready;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rresp = s_r.rresp;
	assign s_axi_rdata = s_r.rdata;
	assign irq = s_r.irq;
endmodule // analog_input_acquisition_modes

// ---- rtl/cycle_timer.sv ----
// file: scan cycle timer, factor times 100 us or 25 us for factor zero
`timescale 1ns/1ps
module cycle_timer #(
	parameter int BASE_CYC = 12500,
	parameter int FAST_CYC = 3125
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic restart,
	input wire logic [9:0] factor,
	output logic tick
);
	localparam int CW = $clog2(BASE_CYC + 1);
	generate
		if (FAST_CYC < 1 || FAST_CYC > BASE_CYC) begin : g_bad
			$error("cycle_timer: fast cycle must lie in 1..BASE_CYC");
		end
	endgenerate
	typedef struct packed {
		logic [CW-1:0] cyc; // cycles inside a unit
		logic [9:0] unit; // units inside a scan cycle
		logic tick;
	} tmr_s;
	tmr_s s_r, s_nxt;
	logic unit_end;
	// count cycles to a unit, units to the factor
	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		unit_end = (factor == 10'h000) ? (s_r.cyc == CW'(FAST_CYC - 1))
			: (s_r.cyc == CW'(BASE_CYC - 1));
		if (restart) begin
			s_nxt.cyc = '0;
			s_nxt.unit = '0;
		end else if (unit_end) begin
			s_nxt.cyc = '0;
			if (factor == 10'h000 || s_r.unit == factor - 10'h001) begin
				s_nxt.unit = '0;
				s_nxt.tick = 1'b1;
			end else begin
				s_nxt.unit = s_r.unit + 10'h001;
			end
		end else begin
			s_nxt.cyc = s_r.cyc + CW'(1);
		end
	end
	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
	assign tick = s_r.tick;
endmodule // cycle_timer

// ---- rtl/sample_mem.sv ----
// file: recording memory, one write port and one registered read port
`timescale 1ns/1ps
module sample_mem #(
	parameter int AW = 16,
	parameter int DW = 16
) (
	input wire logic aclk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);
	generate
		if (AW < 1 || DW < 1) begin : g_bad
			$error("sample_mem: widths must be positive");
		end
	endgenerate
	logic [DW-1:0] mem [0:(1 << AW) - 1]; // sample store
	// write and read, one cycle read latency
	always_ff @(posedge aclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule // sample_mem
